// ==== shared/spe_consts.svh ====
`ifndef SPE_CONSTS_SVH
`define SPE_CONSTS_SVH
`define SPE_DATA_W 8
`define SPE_RX_RESET 8'h00
`define SPE_TX_RESET 8'h00
`define SPE_BIT_CNT_W 4
`define SPE_HALF_DIV 4'h3
`endif

// ==== shared/spe_pkg.sv ====
package spe_pkg;
  typedef logic [7:0] spe_byte_t;
  typedef enum logic [1:0] {SPE_IDLE, SPE_SHIFT, SPE_DONE} spe_state_t;
endpackage : spe_pkg

// ==== src/spe_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin inputs.
module spe_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
  output logic [WIDTH-1:0] sync_out // Levels in clk_in domain.
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } spe_sync_t;
  spe_sync_t s_q, s_d;
  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule : spe_sync

// ==== src/spe_ctrl.sv ====
`timescale 1ns/1ps
`include "spe_consts.svh"
// Operation
// - With cs0 hold and mode-fault detection enabled, no transfer ever starts.
// - In slave role a disable request is ignored; operation continues.
// - Disable leaves tx empty flag; writes while disabled dropped, flag kept.
// - DMA words written after disable are lost.
module spe_ctrl #(
  parameter int DATA_W = `SPE_DATA_W
) (
  input wire logic clk_in, // 200 MHz clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic enable_in, // Pulse: enable the controller.
  input wire logic disable_in, // Pulse: disable request.
  input wire logic soft_reset_bit_in, // Pulse: soft reset.
  input wire logic master_in, // 1 master role, 0 slave role.
  input wire logic cs_hold_after_transfer_in, // Chip select 0 hold option.
  input wire logic mode_fault_detect_disable_in, // 1 disables mode fault.
  input wire logic tx_wr_in, // Pulse: write tx_data_register.
  input wire spe_pkg::spe_byte_t tx_data_in, // Word to transmit.
  input wire logic rx_rd_in, // Pulse: read received word.
  input wire logic sck_in, // Link clock from peer (slave role).
  input wire logic cs_n_in, // Chip select from peer, active low.
  input wire logic mosi_in, // Data from peer.
  input wire logic miso_in, // Data from peer in master role.
  output logic sck_out, // Link clock driven in master role.
  output logic sck_oe_out, // High while sck is driven.
  output logic cs_n_out, // Chip select 0, active low.
  output logic mosi_out, // Serial data out in master role.
  output logic miso_out, // Serial data out in slave role.
  output logic miso_oe_out, // High while miso is driven.
  output logic enabled_out, // Controller enabled status.
  output logic tx_empty_flag_out, // Transmit register empty.
  output logic rx_full_out, // A received word waits.
  output spe_pkg::spe_byte_t rx_data_out, // Last received word.
  output logic busy_out // Transfer in progress.
);
  import spe_pkg::*;
  localparam int CW = `SPE_BIT_CNT_W;
  localparam logic [CW-1:0] LAST = CW'(DATA_W - 1);
  localparam logic [CW-1:0] HALF = CW'(`SPE_HALF_DIV);

  typedef struct packed {
    spe_state_t st;
    logic en;
    logic tde;
    logic rxf;
    logic [DATA_W-1:0] txr;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] rx;
    logic [CW-1:0] bits;
    logic [CW-1:0] div;
    logic sck;
    logic cs;
    logic mst;
    logic sck_prev;
  } spe_state_s_t;
  spe_state_s_t s_q, s_d;

  // One serial step: the word moves up and the new bit enters at the bottom.
  function automatic logic [DATA_W-1:0] shift_in(
    input logic [DATA_W-1:0] word,
    input logic bit_in
  );
    return {word[DATA_W-2:0], bit_in};
  endfunction : shift_in

  logic sck_s, cs_s, mosi_s, miso_s;
  logic start_ok, rise, fall, sin;

  // Peer pins are asynchronous, so they are synchronised first.
  spe_sync #(.WIDTH(4)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({sck_in, cs_n_in, mosi_in, miso_in}),
    .sync_out({sck_s, cs_s, mosi_s, miso_s})
  );

  // Edges of the peer clock and the serial input of the active role.
  always_comb begin
    rise = sck_s && !s_q.sck_prev;
    fall = !sck_s && s_q.sck_prev;
    sin = s_q.mst ? miso_s : mosi_s;
    // The hold option with mode-fault active stalls the start forever.
    start_ok = !(cs_hold_after_transfer_in &&
                 !mode_fault_detect_disable_in);
  end

  // Whole controller next-state logic.
  always_comb begin
    s_d = s_q;
    s_d.sck_prev = sck_s;
    if (rx_rd_in) begin
      s_d.rxf = 1'b0;
    end
    if (enable_in) begin
      s_d.en = 1'b1;
      s_d.mst = master_in;
    end
    // A slave ignores disable; only soft reset stops it.
    if (disable_in && s_q.mst) begin
      s_d.en = 1'b0;
    end
    // Writes are filtered while disabled and the flag is untouched.
    if (tx_wr_in && s_q.en) begin
      s_d.txr = tx_data_in;
      s_d.tde = 1'b0;
    end
    unique case (s_q.st)
      SPE_IDLE: begin
        s_d.cs = s_q.mst ? s_q.cs : 1'b1;
        if (s_q.en && !s_q.tde && start_ok) begin
          if (s_q.mst || !cs_s) begin
            s_d.st = SPE_SHIFT;
            s_d.sh = s_q.txr;
            s_d.tde = 1'b1;
            s_d.bits = '0;
            s_d.div = '0;
            // A slave never drives chip select; only a master asserts it.
            s_d.cs = !s_q.mst;
          end
        end
      end
      SPE_SHIFT: begin
        if (s_q.mst) begin
          s_d.div = s_q.div + 1'b1;
          if (s_q.div == HALF) begin
            s_d.div = '0;
            s_d.sck = !s_q.sck;
            // Data moves only on the falling edge, so the peer's rising
            // sample never races a changing output bit. The synchronised
            // input still shows the bit that stood during the high phase.
            if (s_q.sck) begin
              s_d.sh = shift_in(s_q.sh, sin);
              if (s_q.bits == LAST) begin
                s_d.st = SPE_DONE;
              end else begin
                s_d.bits = s_q.bits + 1'b1;
              end
            end
          end
        end else if (cs_s) begin
          s_d.st = SPE_IDLE;
        end else if (rise) begin
          s_d.sh = shift_in(s_q.sh, sin);
          if (s_q.bits == LAST) begin
            s_d.st = SPE_DONE;
          end
        end else if (fall) begin
          s_d.bits = s_q.bits + 1'b1;
        end
      end
      SPE_DONE: begin
        s_d.rx = s_q.sh;
        s_d.rxf = 1'b1;
        s_d.st = SPE_IDLE;
        s_d.cs = !(s_q.mst && cs_hold_after_transfer_in);
      end
      default: s_d.st = SPE_IDLE;
    endcase
    // Soft reset forces every field but sck_prev back, disabled in either role.
    if (soft_reset_bit_in) begin
      s_d = '{st: SPE_IDLE, en: 1'b0, tde: 1'b1, rxf: 1'b0,
              txr: `SPE_TX_RESET, sh: '0, rx: `SPE_RX_RESET,
              bits: '0, div: '0, sck: 1'b0, cs: 1'b1, mst: 1'b0,
              sck_prev: sck_s};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '{st: SPE_IDLE, en: 1'b0, tde: 1'b1, rxf: 1'b0,
               txr: `SPE_TX_RESET, sh: '0, rx: `SPE_RX_RESET,
               bits: '0, div: '0, sck: 1'b0, cs: 1'b1, mst: 1'b0,
               sck_prev: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Pins and status come from flops; the two enables and busy_out are gated from them.
  assign sck_out = s_q.sck;
  assign sck_oe_out = s_q.mst && s_q.en;
  assign cs_n_out = s_q.cs;
  assign mosi_out = s_q.sh[DATA_W-1];
  assign miso_out = s_q.sh[DATA_W-1];
  assign miso_oe_out = !s_q.mst && s_q.en && !cs_s;
  assign enabled_out = s_q.en;
  assign tx_empty_flag_out = s_q.tde;
  assign rx_full_out = s_q.rxf;
  assign rx_data_out = s_q.rx;
  assign busy_out = (s_q.st != SPE_IDLE);

  // Hang configuration never leaves idle with pending data.
  hang_no_start_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == SPE_IDLE && cs_hold_after_transfer_in &&
     !mode_fault_detect_disable_in && !soft_reset_bit_in)
    |=> s_q.st == SPE_IDLE)
    else $error("transfer started in hang configuration");
  // A slave stays enabled through a disable request.
  slave_disable_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (disable_in && !s_q.mst && s_q.en && !soft_reset_bit_in) |=> s_q.en)
    else $error("slave was disabled by a disable request");
  // The empty flag keeps whatever value it had when disabled.
  tx_flag_kept_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (!s_q.en && s_q.st == SPE_IDLE) |=> $stable(s_q.tde)
      || $past(soft_reset_bit_in))
    else $error("empty flag changed while disabled");
  // Words arriving while disabled are lost; a soft reset may still clear.
  dma_drop_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (tx_wr_in && !s_q.en && !soft_reset_bit_in) |=> $stable(s_q.txr))
    else $error("write accepted while disabled");
  // Soft reset leaves nothing of the previous role or transfer.
  soft_reset_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    soft_reset_bit_in |=> (!s_q.en && s_q.tde && !s_q.rxf
                           && s_q.st == SPE_IDLE && s_q.cs))
    else $error("soft reset left state behind");
endmodule : spe_ctrl

// ==== test/spe_peer.sv ====
`timescale 1ns/1ps
// Far end of the link: listens as slave, can also drive as master.
module spe_peer (
  input wire logic sck_in, // Link clock from the block.
  input wire logic cs_n_in, // Chip select from the block, active low.
  input wire logic mosi_in, // Data from the block.
  input wire logic miso_in, // Reply data from the block in slave role.
  output logic miso_out, // Reply data to the block.
  output logic sck_out, // Link clock when the peer leads.
  output logic cs_n_out, // Chip select when the peer leads.
  output logic mosi_out, // Data when the peer leads.
  output spe_pkg::spe_byte_t rx_out // Last word heard.
);
  import spe_pkg::*;
  spe_byte_t tx_q = 8'h00;
  // Lines start quiet; the clock stands low outside frames.
  initial begin
    miso_out = 1'b0;
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rx_out = 8'h00;
  end
  // Next bit goes out on select and on each falling clock edge.
  always @(negedge cs_n_in or negedge sck_in) begin
    if (!cs_n_in) begin
      miso_out <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
  // A released line flips, so a stale bit never reads as a good one.
  always @(posedge cs_n_in) miso_out <= ~miso_out;
  // Incoming bits are taken on the rising clock edge.
  always @(posedge sck_in) begin
    if (!cs_n_in) rx_out <= {rx_out[6:0], mosi_in};
  end
  task automatic load(spe_byte_t b);
    tx_q = b;
  endtask : load
  // One whole frame, most significant bit first, 64 ns clock period.
  // The block's reply is taken just before each rising edge.
  task automatic send(spe_byte_t b, output spe_byte_t got);
    got = 8'h00;
    cs_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = b[i];
      #32 got = {got[6:0], miso_in};
      sck_out = 1'b1;
      #32 sck_out = 1'b0;
    end
    #32 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask : send
endmodule : spe_peer

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import spe_pkg::*;
  logic clk_in = 0, rst_n_in = 0, enable_in = 0, disable_in = 0;
  logic soft_reset_bit_in = 0, master_in = 0, tx_wr_in = 0, rx_rd_in = 0;
  logic cs_hold_after_transfer_in = 0, mode_fault_detect_disable_in = 1;
  spe_byte_t tx_data_in = 8'h00, rx_data_out, p_rx;
  logic p_sck, p_cs_n, p_mosi, p_miso, sck_out, sck_oe_out, cs_n_out;
  logic mosi_out, miso_out, miso_oe_out, enabled_out, tx_empty_flag_out;
  logic rx_full_out, busy_out;
  int miscompares = 0, checks = 0;
  spe_ctrl uut (.clk_in, .rst_n_in, .enable_in, .disable_in,
    .soft_reset_bit_in, .master_in, .cs_hold_after_transfer_in,
    .mode_fault_detect_disable_in, .tx_wr_in, .tx_data_in, .rx_rd_in,
    .sck_in(p_sck), .cs_n_in(p_cs_n), .mosi_in(p_mosi), .miso_in(p_miso),
    .sck_out, .sck_oe_out, .cs_n_out, .mosi_out, .miso_out, .miso_oe_out,
    .enabled_out, .tx_empty_flag_out, .rx_full_out, .rx_data_out, .busy_out);
  spe_peer peer (.sck_in(sck_out), .cs_n_in(cs_n_out), .mosi_in(mosi_out),
    .miso_in(miso_out), .miso_out(p_miso), .sck_out(p_sck), .cs_n_out(p_cs_n),
    .mosi_out(p_mosi), .rx_out(p_rx));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'b1;
    @(negedge clk_in) s = 1'b0;
  endtask : pulse
  task automatic wr(spe_byte_t b);
    @(negedge clk_in) tx_data_in = b;
    tx_wr_in = 1'b1;
    @(negedge clk_in) tx_wr_in = 1'b0;
  endtask : wr
  // Bounded wait, so a transfer that never ends cannot hang the run.
  task automatic wait_rx;
    int n = 0;
    while (rx_full_out !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
  endtask : wait_rx
  task automatic chk_clear;
    chk("enabled", 0, enabled_out);
    chk("tx_empty", 1, tx_empty_flag_out);
    chk("rx_full", 0, rx_full_out);
    chk("busy", 0, busy_out);
    chk("cs_n", 1, cs_n_out);
  endtask : chk_clear
  task automatic xfer(spe_byte_t t, spe_byte_t r);
    peer.load(r);
    wr(t);
    wait_rx();
    chk("rx_data", r, rx_data_out);
    chk("peer_rx", t, p_rx);
    pulse(rx_rd_in);
    chk("rx_full", 0, rx_full_out);
  endtask : xfer
  task automatic restart(logic m);
    pulse(soft_reset_bit_in);
    master_in = m;
    pulse(enable_in);
  endtask : restart
  task automatic t_hang;
    master_in = 1'b1;
    pulse(enable_in);
    cs_hold_after_transfer_in = 1'b1;
    mode_fault_detect_disable_in = 1'b0;
    wr(8'h5A);
    repeat (100) @(negedge clk_in);
    chk("busy", 0, busy_out);
    chk("cs_n", 1, cs_n_out);
    chk("tx_empty", 0, tx_empty_flag_out);
    restart(1'b1);
    mode_fault_detect_disable_in = 1'b1;
    xfer(8'hA5, 8'h3C);
    cs_hold_after_transfer_in = 1'b0;
    $display("test hang done");
  endtask : t_hang
  task automatic t_disable;
    restart(1'b1);
    // Stall the start so a word is still pending when disabled.
    cs_hold_after_transfer_in = 1'b1;
    mode_fault_detect_disable_in = 1'b0;
    wr(8'h3C);
    pulse(disable_in);
    chk("enabled", 0, enabled_out);
    chk("tx_empty", 0, tx_empty_flag_out);
    chk("sck_oe", 0, sck_oe_out);
    cs_hold_after_transfer_in = 1'b0;
    mode_fault_detect_disable_in = 1'b1;
    repeat (3) wr(8'hC3);
    chk("tx_empty", 0, tx_empty_flag_out);
    repeat (20) @(negedge clk_in);
    chk("busy", 0, busy_out);
    chk("rx_full", 0, rx_full_out);
    restart(1'b1);
    xfer(8'h81, 8'h7E);
    $display("test disable done");
  endtask : t_disable
  task automatic t_slave;
    spe_byte_t got;
    restart(1'b0);
    wr(8'h69);
    pulse(disable_in);
    chk("enabled", 1, enabled_out);
    chk("sck_oe", 0, sck_oe_out);
    peer.send(8'hB4, got);
    wait_rx();
    chk("rx_data", 8'hB4, rx_data_out);
    chk("slave_tx", 8'h69, got);
    pulse(rx_rd_in);
    pulse(soft_reset_bit_in);
    chk_clear();
    $display("test slave done");
  endtask : t_slave
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // 200 MHz clock.
  initial forever #2.5 clk_in = ~clk_in;
  // Main sequence; reset is held for three clock cycles.
  initial begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk_clear();
    t_hang();
    t_disable();
    t_slave();
    end_of_test();
  end
  // Watchdog well past the few hundred cycles the tests need.
  initial begin
    #60000;
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
